/* common/sdm_consts.svh */
// Purpose: constants for the sdram address mapper
// Assumes: included by bare name from the mapper, the field extractor and the bench top
// Notes:   definitions only
`ifndef SDM_CONSTS_SVH
`define SDM_CONSTS_SVH

// flat system address width
`define SDM_ADDR_W       28
// width of a shift amount into the address
`define SDM_LSB_W        5
// width of a field-width count
`define SDM_CNT_W        4
// byte offset widths per data bus width
`define SDM_OFF_BITS_32  4'h2
`define SDM_OFF_BITS_16  4'h1
// column field is 8 bits plus the column code
`define SDM_COL_BASE     4'h8
// row field is 11 bits plus the row code
`define SDM_ROW_BASE     4'hB
// row code with no defined geometry
`define SDM_ROW_RSVD     2'h3
// row code the reserved one falls back to (8K rows)
`define SDM_ROW_MAX      2'h2
// bank field width
`define SDM_BANK_BITS    4'h2
// widest column and row fields
`define SDM_COL_W        11
`define SDM_ROW_W        13

`endif

/* common/sdm_pkg.sv */
// Purpose: shared types of the sdram address mapper
// Assumes: nothing
// Notes:   numeric constants live in sdm_consts.svh
package sdm_pkg;

	// memory data bus width selection
	typedef enum logic {
		SDM_BUS16,
		SDM_BUS32
	} sdm_bus_t;

	// column count selection
	typedef enum logic [1:0] {
		SDM_COL256,
		SDM_COL512,
		SDM_COL1024,
		SDM_COL2048
	} sdm_col_t;

	// row count selection
	typedef enum logic [1:0] {
		SDM_ROW2K,
		SDM_ROW4K,
		SDM_ROW8K,
		SDM_ROWRSVD
	} sdm_row_t;

endpackage

/* logic/sdm_address_mapper.sv */
// Purpose: split a flat address into offset, column, row and bank
// Assumes: configuration inputs are stable while requests flow
// Notes:   one cycle from request to registered decode
`timescale 1ns/1ps
`include "sdm_consts.svh"

module sdm_address_mapper
	import sdm_pkg::*;
#(
	parameter int ADDR_W = `SDM_ADDR_W
) (
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// geometry configuration
	input  wire sdm_bus_t          busWidth,
	input  wire sdm_col_t          colCount,
	input  wire sdm_row_t          rowCount,
	// address request
	input  wire logic              reqValid,
	input  wire logic [ADDR_W-1:0] addrIn,
	// decoded fields
	output logic                   decodeValid,
	output logic [1:0]             byteOffset,
	output logic [`SDM_COL_W-1:0]  column,
	output logic [`SDM_ROW_W-1:0]  row,
	output logic [1:0]             bankField,
	output logic                   cfgError,
	// sdram bank-select pins
	output logic                   bankSel1,
	output logic                   bankSel0
);

	logic [`SDM_CNT_W-1:0] offBits;
	logic [`SDM_CNT_W-1:0] colBits;
	logic [`SDM_CNT_W-1:0] rowBits;
	logic [1:0]            rowCode;
	logic [`SDM_LSB_W-1:0] colLsb;
	logic [`SDM_LSB_W-1:0] rowLsb;
	logic [`SDM_LSB_W-1:0] bankLsb;
	logic [`SDM_COL_W-1:0] colRaw;
	logic [`SDM_ROW_W-1:0] rowRaw;
	logic [1:0]            bankRaw;
	logic [1:0]            offRaw;

	logic                  next_decodeValid;
	logic [1:0]            next_byteOffset;
	logic [`SDM_COL_W-1:0] next_column;
	logic [`SDM_ROW_W-1:0] next_row;
	logic [1:0]            next_bankField;
	logic                  next_cfgError;

	// field widths and positions from the geometry
	always_comb begin
		// only the two supported widths pick an offset size
		if (busWidth == SDM_BUS32) begin
			offBits = `SDM_OFF_BITS_32;
		end else begin
			offBits = `SDM_OFF_BITS_16;
		end
		colBits = `SDM_COL_BASE + `SDM_CNT_W'(colCount);
		// reserved row code decodes as the widest row
		if (rowCount == `SDM_ROW_RSVD) begin
			rowCode = `SDM_ROW_MAX;
		end else begin
			rowCode = rowCount;
		end
		rowBits = `SDM_ROW_BASE + `SDM_CNT_W'(rowCode);
		colLsb  = `SDM_LSB_W'(offBits);
		rowLsb  = colLsb + `SDM_LSB_W'(colBits);
		bankLsb = rowLsb + `SDM_LSB_W'(rowBits);
	end

	// byte offset bits, high bit unused on the 16-bit bus
	always_comb begin
		if (busWidth == SDM_BUS32) begin
			offRaw = addrIn[1:0];
		end else begin
			offRaw = {1'b0, addrIn[0]};
		end
	end

	// column field extractor
	sdm_field_extract #(
		.ADDR_W  (ADDR_W),
		.FIELD_W (`SDM_COL_W)
	) u_col (
		.addr  (addrIn),
		.lsb   (colLsb),
		.width (colBits),
		.field (colRaw)
	);

	// row field extractor
	sdm_field_extract #(
		.ADDR_W  (ADDR_W),
		.FIELD_W (`SDM_ROW_W)
	) u_row (
		.addr  (addrIn),
		.lsb   (rowLsb),
		.width (rowBits),
		.field (rowRaw)
	);

	// bank extractor masks off everything above the bank
	sdm_field_extract #(
		.ADDR_W  (ADDR_W),
		.FIELD_W (2)
	) u_bank (
		.addr  (addrIn),
		.lsb   (bankLsb),
		.width (`SDM_BANK_BITS),
		.field (bankRaw)
	);

	// next decode values; fields hold between requests
	always_comb begin
		next_decodeValid = reqValid;
		next_byteOffset  = byteOffset;
		next_column      = column;
		next_row         = row;
		next_bankField   = bankField;
		next_cfgError    = cfgError;
		if (reqValid) begin
			next_byteOffset = offRaw;
			next_column     = colRaw;
			next_row        = rowRaw;
			next_bankField  = bankRaw;
			next_cfgError   = (rowCount == `SDM_ROW_RSVD);
		end
	end

	// decode registers, frozen while ce is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			decodeValid <= 1'b0;
			byteOffset  <= 2'h0;
			column      <= 11'h000;
			row         <= 13'h0000;
			bankField   <= 2'h0;
			cfgError    <= 1'b0;
		end else if (ce) begin
			decodeValid <= next_decodeValid;
			byteOffset  <= next_byteOffset;
			column      <= next_column;
			row         <= next_row;
			bankField   <= next_bankField;
			cfgError    <= next_cfgError;
		end
	end

	// bank pins follow the registered bank field
	assign bankSel1 = bankField[1];
	assign bankSel0 = bankField[0];

	logic take;
	assign take = ce && reqValid;

	a_valid_follow: assert property (
		@(posedge clk) disable iff (!nrst)
		ce |=> (decodeValid == $past(reqValid))
	) else $error("decode valid does not follow request");

	a_offset_w32: assert property (
		@(posedge clk) disable iff (!nrst)
		take && busWidth == SDM_BUS32 |=>
			byteOffset == $past(addrIn[1:0])
	) else $error("32-bit byte offset wrong");

	a_offset_w16: assert property (
		@(posedge clk) disable iff (!nrst)
		take && busWidth == SDM_BUS16 |=>
			byteOffset == {1'b0, $past(addrIn[0])}
	) else $error("16-bit byte offset wrong");

	a_column_pos: assert property (
		@(posedge clk) disable iff (!nrst)
		take |=> column == `SDM_COL_W'(
			($past(addrIn) >> ($past(busWidth) == SDM_BUS32 ? 2 : 1))
			& ((1 << (8 + $past(colCount))) - 1))
	) else $error("column field misplaced");

	a_row_pos: assert property (
		@(posedge clk) disable iff (!nrst)
		take && rowCount != `SDM_ROW_RSVD |=> row == `SDM_ROW_W'(
			($past(addrIn) >> (($past(busWidth) == SDM_BUS32 ? 2 : 1)
				+ 8 + $past(colCount)))
			& ((1 << (11 + $past(rowCount))) - 1))
	) else $error("row field misplaced");

	a_bank_pos: assert property (
		@(posedge clk) disable iff (!nrst)
		take && rowCount != `SDM_ROW_RSVD |=> bankField == 2'(
			$past(addrIn) >> (($past(busWidth) == SDM_BUS32 ? 2 : 1)
				+ 19 + $past(colCount) + $past(rowCount)))
	) else $error("bank field misplaced");

	a_bank_pins: assert property (
		@(posedge clk) disable iff (!nrst)
		take |=> {bankSel1, bankSel0} == $past(bankRaw)
	) else $error("bank pins do not carry decoded bank");

	a_off_narrow: assert property (
		@(posedge clk) disable iff (!nrst)
		take && busWidth == SDM_BUS16 |=> !byteOffset[1]
	) else $error("16-bit offset uses two bits");

	a_upper_ignored: assert property (
		@(posedge clk) disable iff (!nrst)
		take |=> bankField == 2'(
			$past(addrIn) >> (($past(busWidth) == SDM_BUS32 ? 2 : 1)
				+ 19 + $past(colCount)
				+ ($past(rowCount) == SDM_ROWRSVD ? 2 : $past(rowCount))))
	) else $error("bits above bank leak into decode");

endmodule

/* logic/sdm_field_extract.sv */
// Purpose: pull a variable-width field out of an address
// Assumes: lsb and width stay inside the address
// Notes:   purely combinational
`timescale 1ns/1ps
`include "sdm_consts.svh"

module sdm_field_extract
	import sdm_pkg::*;
#(
	parameter int ADDR_W  = `SDM_ADDR_W,
	parameter int FIELD_W = `SDM_ROW_W
) (
	// source address
	input  wire logic [ADDR_W-1:0]    addr,
	// field position and size
	input  wire logic [`SDM_LSB_W-1:0] lsb,
	input  wire logic [`SDM_CNT_W-1:0] width,
	// extracted field, upper bits zero
	output logic      [FIELD_W-1:0]   field
);

	// all-ones mask of the given width
	function automatic logic [ADDR_W-1:0] width_mask(
		input logic [`SDM_CNT_W-1:0] w
	);
		logic [ADDR_W-1:0] one;
		one = {{(ADDR_W-1){1'b0}}, 1'b1};
		width_mask = (one << w) - one;
	endfunction

	logic [ADDR_W-1:0] shifted;

	// shift down then mask to the field width
	always_comb begin
		shifted = (addr >> lsb) & width_mask(width);
		field = shifted[FIELD_W-1:0];
	end

endmodule

/* testbench/sdm_address_mapper_tb_top.sv */
// Purpose: self-checking bench for the address mapper
// Assumes: one cycle from taken request to decode
// Notes:   driver queues predictions, monitor pops them
`timescale 1ns/1ps
`include "sdm_consts.svh"

module sdm_address_mapper_tb_top
	import sdm_pkg::*;
;
	typedef struct {
		logic [1:0]  off;
		logic [10:0] col;
		logic [12:0] row;
		logic [1:0]  bank;
		logic        err;
	} sdm_exp_t;

	logic                   clk;
	logic                   nrst;
	logic                   ce;
	sdm_bus_t               busWidth;
	sdm_col_t               colCount;
	sdm_row_t               rowCount;
	logic                   reqValid;
	logic [27:0]            addrIn;
	logic                   decodeValid;
	logic [1:0]             byteOffset;
	logic [`SDM_COL_W-1:0]  column;
	logic [`SDM_ROW_W-1:0]  row;
	logic [1:0]             bankField;
	logic                   cfgError;
	logic                   bankSel1;
	logic                   bankSel0;
	logic [1:0]             bankNum;
	logic                   ceLast = 1'b0;
	int                     seed = 86405;
	int                     err_total = 0;
	int                     compares = 0;
	sdm_exp_t               q[$];
	sdm_exp_t               got;

	sdm_address_mapper i_dut (.clk(clk), .nrst(nrst), .ce(ce),
		.busWidth(busWidth), .colCount(colCount), .rowCount(rowCount),
		.reqValid(reqValid), .addrIn(addrIn), .decodeValid(decodeValid),
		.byteOffset(byteOffset), .column(column), .row(row),
		.bankField(bankField), .cfgError(cfgError),
		.bankSel1(bankSel1), .bankSel0(bankSel0));

	sdm_sdram_model i_mem (.bankSel1(bankSel1), .bankSel0(bankSel0),
		.bankNum(bankNum));

	// field split worked out from the geometry
	function automatic sdm_exp_t predict(logic [27:0] a, int b, int c,
		int r);
		sdm_exp_t e;
		int       off;
		int       cw;
		int       rw;
		off = b ? 2 : 1;
		cw = 8 + c;
		rw = 11 + ((r == 3) ? 2 : r);
		e.off = b ? a[1:0] : {1'b0, a[0]};
		e.col = 11'((a >> off) & ((28'h1 << cw) - 28'h1));
		e.row = 13'((a >> (off + cw)) & ((28'h1 << rw) - 28'h1));
		e.bank = 2'((a >> (off + cw + rw)) & 28'h3);
		e.err = (r == 3);
		return e;
	endfunction

	task automatic fail(string m);
		err_total++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask

	task automatic wrap_up();
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog
	initial begin
		#50000;
		err_total++;
		wrap_up();
	end

	// monitor: one new decode per edge that had ce high
	always @(posedge clk) begin
		if (decodeValid === 1'b1 && ceLast === 1'b1) begin
			if (q.size() == 0) begin
				fail("decode with no request");
			end else begin
				got = q.pop_front();
				compares += 6;
				if (byteOffset !== got.off) fail("byte offset");
				if (column !== got.col) fail("column");
				if (row !== got.row) fail("row");
				if (bankField !== got.bank) fail("bank");
				if (bankNum !== got.bank) fail("bank pins");
				if (cfgError !== got.err) fail("config flag");
			end
		end
		ceLast = ce;
	end

	// stimulus: every geometry, random gaps and addresses
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		busWidth = SDM_BUS16;
		colCount = SDM_COL256;
		rowCount = SDM_ROW2K;
		reqValid = 1'b0;
		addrIn = 28'h0000000;
		repeat (6) @(posedge clk);
		#1 nrst = 1'b1;
		for (int b = 0; b < 2; b++) begin
			for (int c = 0; c < 4; c++) begin
				for (int r = 0; r < 4; r++) begin
					for (int k = 0; k < 8; k++) begin
						@(posedge clk);
						#1;
						busWidth = sdm_bus_t'(b);
						colCount = sdm_col_t'(c);
						rowCount = sdm_row_t'(r);
						addrIn = (k == 0) ? 28'hFFFFFFF : 28'($random(seed));
						reqValid = (k < 2) ? 1'b1 : 1'($random(seed));
						if (reqValid) q.push_back(predict(addrIn, b, c, r));
					end
				end
			end
		end
		@(posedge clk);
		#1 reqValid = 1'b0;
		repeat (2) @(posedge clk);
		// frozen requests must not be taken
		#1 ce = 1'b0;
		reqValid = 1'b1;
		repeat (3) @(posedge clk);
		#1 reqValid = 1'b0;
		ce = 1'b1;
		repeat (3) @(posedge clk);
		// mid-run reset clears the decode, then a request at once
		#1 nrst = 1'b0;
		@(posedge clk);
		#1 compares++;
		if ({decodeValid, byteOffset, column, row, bankField, cfgError,
			bankNum} !== '0) fail("reset state");
		nrst = 1'b1;
		busWidth = SDM_BUS32;
		colCount = SDM_COL2048;
		rowCount = SDM_ROW8K;
		addrIn = 28'($random(seed));
		reqValid = 1'b1;
		q.push_back(predict(addrIn, 1, 3, 2));
		@(posedge clk);
		#1 reqValid = 1'b0;
		repeat (3) @(posedge clk);
		#1 compares++;
		if (q.size() != 0) fail("requests left undecoded");
		wrap_up();
	end
endmodule

/* testbench/sdm_sdram_model.sv */
// Purpose: far-side memory view of the bank-select pins
// Assumes: pins are read while a decode is shown
// Notes:   behavioural, no timing of its own
`timescale 1ns/1ps

module sdm_sdram_model (
	// bank-select pins from the mapper
	input  wire logic       bankSel1,
	input  wire logic       bankSel0,
	// bank the memory would open
	output logic      [1:0] bankNum
);
	// upper pin is the upper bank bit
	assign bankNum = {bankSel1, bankSel0};
endmodule
